// File: pp_protect_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 200 MHz aclk and 32-bit axi4-lite access to word registers
// What this block does
// RULE_01: overtemperature disables source switch, enters error recovery
// RULE_02: contract-based source overvoltage disables switch, error recovery
// RULE_03: rail undervoltage with switch on forces error recovery
// RULE_04: reverse current turns source off, auto restore
// RULE_05: fast turn-on engages switch below reverse margin
// RULE_06: cable switch current clamp while supplying vconn
// RULE_07: overtemperature latches cable switch off, error recovery
// RULE_08: rail undervoltage disables both cable switches
// RULE_09: sink ovp off until enabled, cuts system gate
// RULE_10: upper overvoltage cuts vbus gate, hysteretic restore (code restores once the upper flag drops, without waiting for the clear flag)
// RULE_11: dead battery boot ovp holds both gates off
// RULE_12: system above vbus cuts vbus gate, restore
// RULE_13: vbus undervoltage cuts vbus gate, restore
// RULE_14: unattached state applies vbus discharge
// RULE_15: both cc open: monitor, no power
// RULE_16: single rd: vbus only, watch rd pin
// RULE_17: single ra: no power, watch both roles
// RULE_18: ra plus rd: vbus and vconn on ra
// RULE_19: rd-rd debug, ra-ra audio accessory
// RULE_20: default advertisement until source switch closes
// RULE_21: disconnect after debounce above threshold
// RULE_22: sink presents pulldown, vbus means attach, decode current
// RULE_23: comparator flags synchronised and qualified once
// RULE_24: per-port sticky fault status readable by firmware
`ifndef PP_PROTECT_REGS_SVH
`define PP_PROTECT_REGS_SVH
`define CTRL_OFFSET      8'h00
`define STATUS_OFFSET    8'h04
`define FAULT_OFFSET     8'h08
`define CTRL_RESET       32'h0000_0000
`define CTRL_SRC_EN      0
`define CTRL_SNK_MODE    1
`define CTRL_FRS_EN      2
`define CTRL_OVP_EN      3
`define CTRL_ADV_LO      4
`define CTRL_ADV_HI      5
`define CTRL_BOOT_MODE   6
`define CTRL_ER_CLEAR    7
`define CTRL_WIDTH       8
`define CC_DEBOUNCE_US   150
`define CC_DEBOUNCE_CYC  ((`CC_DEBOUNCE_US * 1000) / 5)
`define QUAL_CYC         4
`endif

// File: pp_protect_pkg.sv
// types shared by the power path protection block
// assumes the constants header is included alongside
package pp_protect_pkg;
	typedef enum logic [1:0] {
		cc_open = 2'h0,
		cc_ra   = 2'h1,
		cc_rd   = 2'h2
	} cc_term_e;
	typedef enum logic [3:0] {
		st_unattached = 4'h1,
		st_attached   = 4'h2,
		st_error      = 4'h4,
		st_sink       = 4'h8
	} port_state_e;
	typedef enum logic [1:0] {
		adv_default = 2'h0,
		adv_1a5     = 2'h1,
		adv_3a0     = 2'h2
	} adv_t;
endpackage

// File: flag_qualifier.sv
// three-stage synchroniser with agreement filter for an analog flag
// assumes the flag is asynchronous to aclk
`include "pp_protect_regs.svh"
module flag_qualifier (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic flag_raw,
	output logic      flag_q,
	output logic      rise
);
	logic [2:0] sync_q;
	logic [2:0] cnt_q;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sync_q <= 3'h0;
		else
			sync_q <= {sync_q[1:0], flag_raw};
	end
	// a change needs stages two and three agreeing for several cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= 3'h0;
			flag_q <= 1'b0;
			rise   <= 1'b0;
		end else begin
			rise <= 1'b0;
			if (sync_q[1] == sync_q[2] && sync_q[2] != flag_q) begin
				if (cnt_q == 3'(`QUAL_CYC - 1)) begin
					cnt_q  <= 3'h0;
					flag_q <= sync_q[2]; // RULE_23
					rise   <= sync_q[2];
				end else begin
					cnt_q <= cnt_q + 3'h1;
				end
			end else begin
				cnt_q <= 3'h0;
			end
		end
	end
endmodule

// File: cc_debounce.sv
// holds a high level for the debounce time before reporting it; a low is reported at once
// assumes the input is already on aclk
`include "pp_protect_regs.svh"
module cc_debounce #(
	parameter int unsigned CYCLES = `CC_DEBOUNCE_CYC
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic level,
	output logic      stable_q
);
	logic [15:0] cnt_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q    <= 16'h0;
			stable_q <= 1'b0;
		end else if (!level) begin
			cnt_q    <= 16'h0;
			stable_q <= 1'b0;
		end else if (cnt_q == 16'(CYCLES - 1)) begin
			stable_q <= 1'b1; // RULE_21
		end else begin
			cnt_q <= cnt_q + 16'h1;
		end
	end
endmodule

// File: typec_power_path_protect.sv
// one port of power path protection, sink gate control and cc attach
// assumes comparator flags from analog sensing and an axi4-lite master
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`include "pp_protect_regs.svh"
module typec_power_path_protect #(
	parameter int unsigned DEBOUNCE_CYCLES = `CC_DEBOUNCE_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        overtemp_raw,
	input  wire logic        src_ovp_raw,
	input  wire logic        rail_uvlo_raw,
	input  wire logic        src_rcp_raw,
	input  wire logic        vconn_overcurrent_raw,
	input  wire logic        sys_ovp_raw,
	input  wire logic        upper_ovp_raw,
	input  wire logic        upper_ovp_clear_raw,
	input  wire logic        sink_rcp_raw,
	input  wire logic        vbus_uvlo_raw,
	input  wire logic        vbus_present_raw,
	input  wire logic        cc1_rd_raw,
	input  wire logic        cc1_ra_raw,
	input  wire logic        cc2_rd_raw,
	input  wire logic        cc2_ra_raw,
	input  wire logic        cc_disconnect_raw,
	input  wire logic [1:0]  sink_adv_level,
	input  wire logic        safe_strap_configuration,
	output logic             vbus_source_switch,
	output logic             vbus_source_fast_on,
	output logic             vconn_cable_switch,
	output logic             vconn_on_cc2,
	output logic             vconn_current_clamp,
	output logic             sink_system_gate_driver,
	output logic             sink_vbus_gate_driver,
	output logic             vbus_discharge,
	output logic             sink_pulldown_termination,
	output logic [1:0]       source_advertise,
	output logic             detach_watch_cc1,
	output logic             detach_watch_cc2,
	output logic [3:0]       port_state
);
	logic [`CTRL_WIDTH-1:0] ctrl_q;
	logic [7:0]  fault_q;
	logic [7:0]  fault_set;
	logic        aw_held_q, w_held_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic        wr_fire, clear_fault;
	pp_protect_pkg::port_state_e state_q;
	pp_protect_pkg::cc_term_e    cc1_t, cc2_t;
	logic        cable_latched_q;
	logic        vconn_side_q;
	logic        er_entry;

	// qualified comparator flags
	logic [15:0] raw_v, qual_v, rise_v;
	assign raw_v = {cc_disconnect_raw, cc2_ra_raw, cc2_rd_raw, cc1_ra_raw, cc1_rd_raw,
		vbus_present_raw, vbus_uvlo_raw, sink_rcp_raw, upper_ovp_clear_raw, upper_ovp_raw,
		sys_ovp_raw, vconn_overcurrent_raw, src_rcp_raw, rail_uvlo_raw, src_ovp_raw, overtemp_raw};
	for (genvar i = 0; i < 16; i++) begin : g_q
		flag_qualifier u_q (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.flag_raw (raw_v[i]),
			.flag_q   (qual_v[i]),
			.rise     (rise_v[i])
		); // RULE_23
	end
	logic ot, ovp, uvlo, rcp, oc, sovp, uovp, uclr, srcp, vuv, vpres, disc;
	assign ot    = qual_v[0];
	assign ovp   = qual_v[1];
	assign uvlo  = qual_v[2];
	assign rcp   = qual_v[3];
	assign oc    = qual_v[4];
	assign sovp  = qual_v[5];
	assign uovp  = qual_v[6];
	assign uclr  = qual_v[7];
	assign srcp  = qual_v[8];
	assign vuv   = qual_v[9];
	assign vpres = qual_v[10];
	assign disc  = qual_v[15];

	function automatic pp_protect_pkg::cc_term_e cc_decode(input logic rd, input logic ra);
		if (rd)
			return pp_protect_pkg::cc_rd;
		else if (ra)
			return pp_protect_pkg::cc_ra;
		else
			return pp_protect_pkg::cc_open;
	endfunction
	assign cc1_t = cc_decode(qual_v[11], qual_v[12]);
	assign cc2_t = cc_decode(qual_v[13], qual_v[14]);

	// axi4-lite write path
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_fire = aw_held_q && w_held_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_q == `CTRL_OFFSET || awaddr_q == `FAULT_OFFSET) ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_q <= `CTRL_WIDTH'(`CTRL_RESET);
		else if (wr_fire && awaddr_q == `CTRL_OFFSET && s_axi_wstrb[0])
			ctrl_q <= wdata_q[`CTRL_WIDTH-1:0];
	end
	assign clear_fault = wr_fire && awaddr_q == `FAULT_OFFSET && s_axi_wstrb[0];

	// sink side: advertised current level from the cc voltage decode
	logic [1:0] adv_sync1_q, adv_sync2_q, adv_sync3_q;
	logic [1:0] sink_adv_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adv_sync1_q <= 2'h0;
			adv_sync2_q <= 2'h0;
			adv_sync3_q <= 2'h0;
		end else begin
			adv_sync1_q <= sink_adv_level;
			adv_sync2_q <= adv_sync1_q;
			adv_sync3_q <= adv_sync2_q;
		end
	end
	// whole word taken only when two samples agree, so a skewed code is skipped
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sink_adv_q <= 2'h0;
		else if (state_q != pp_protect_pkg::st_sink)
			sink_adv_q <= 2'h0;
		else if (adv_sync2_q == adv_sync3_q)
			sink_adv_q <= adv_sync3_q; // RULE_22
	end

	// axi4-lite read path
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			unique case (s_axi_araddr)
				`CTRL_OFFSET:   s_axi_rdata <= {24'h0, ctrl_q};
				`STATUS_OFFSET: s_axi_rdata <= {22'h0, sink_adv_q, port_state, vconn_cable_switch,
					vbus_source_switch, sink_vbus_gate_driver, sink_system_gate_driver};
				`FAULT_OFFSET:  s_axi_rdata <= {24'h0, fault_q};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// protection events; set wins over clear
	logic src_on;
	assign src_on = vbus_source_switch;
	assign fault_set = {rise_v[9], rise_v[8], rise_v[6], rise_v[5],
		rise_v[2], rise_v[3], rise_v[1] && src_on, rise_v[0]};
	always_ff @(posedge aclk) begin
		if (!aresetn)
			fault_q <= 8'h00;
		else
			fault_q <= (clear_fault ? (fault_q & ~wdata_q[7:0]) : fault_q) | fault_set; // RULE_24
	end
	assign er_entry = rise_v[0] // RULE_01 RULE_07
		|| (rise_v[1] && src_on) // RULE_02
		|| (rise_v[2] && src_on); // RULE_03

	// port state machine
	logic attach_src, debounced_disc;
	assign attach_src = (cc1_t == pp_protect_pkg::cc_rd) || (cc2_t == pp_protect_pkg::cc_rd)
		|| (cc1_t == pp_protect_pkg::cc_ra && cc2_t == pp_protect_pkg::cc_ra); // RULE_19
	cc_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_disc (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.level    (disc),
		.stable_q (debounced_disc)
	);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= pp_protect_pkg::st_unattached;
		end else if (er_entry) begin
			state_q <= pp_protect_pkg::st_error;
		end else begin
			unique case (state_q)
				pp_protect_pkg::st_unattached: begin
					if (ctrl_q[`CTRL_SNK_MODE] && vpres)
						state_q <= pp_protect_pkg::st_sink; // RULE_22
					else if (!ctrl_q[`CTRL_SNK_MODE] && ctrl_q[`CTRL_SRC_EN] && attach_src)
						state_q <= pp_protect_pkg::st_attached; // RULE_15
				end
				pp_protect_pkg::st_attached:
					if (debounced_disc || ctrl_q[`CTRL_SNK_MODE])
						state_q <= pp_protect_pkg::st_unattached; // RULE_21
				pp_protect_pkg::st_error:
					if (ctrl_q[`CTRL_ER_CLEAR] && !ot)
						state_q <= pp_protect_pkg::st_unattached;
				pp_protect_pkg::st_sink:
					if (!vpres || !ctrl_q[`CTRL_SNK_MODE])
						state_q <= pp_protect_pkg::st_unattached;
				default:
					state_q <= pp_protect_pkg::st_unattached;
			endcase
		end
	end
	assign port_state = state_q;

	// vconn side chosen at attach, held during the connection
	always_ff @(posedge aclk) begin
		if (!aresetn)
			vconn_side_q <= 1'b0;
		else if (state_q == pp_protect_pkg::st_unattached)
			vconn_side_q <= (cc2_t == pp_protect_pkg::cc_ra); // RULE_18
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cable_latched_q <= 1'b0;
		else if (rise_v[0])
			cable_latched_q <= 1'b1; // RULE_07
		else if (state_q == pp_protect_pkg::st_unattached && !ot)
			cable_latched_q <= 1'b0;
	end

	logic attached, sink_seen, ra_rd;
	assign attached = state_q == pp_protect_pkg::st_attached;
	assign sink_seen = (cc1_t == pp_protect_pkg::cc_rd) != (cc2_t == pp_protect_pkg::cc_rd);
	assign ra_rd = sink_seen && ((cc1_t == pp_protect_pkg::cc_ra) || (cc2_t == pp_protect_pkg::cc_ra));

	// source and cable switches
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vbus_source_switch  <= 1'b0;
			vbus_source_fast_on <= 1'b0;
			vconn_cable_switch  <= 1'b0;
			vconn_on_cc2        <= 1'b0;
			vconn_current_clamp <= 1'b0;
		end else begin
			vbus_source_switch <= attached && sink_seen && !ot && !uvlo && !ovp && !rcp // RULE_01 RULE_02 RULE_03 RULE_04 RULE_16
				&& !er_entry;
			vbus_source_fast_on <= ctrl_q[`CTRL_FRS_EN] && attached && !rcp; // RULE_05
			vconn_cable_switch <= attached && ra_rd && !cable_latched_q && !ot && !uvlo // RULE_08 RULE_17 RULE_18
				&& !rise_v[0];
			vconn_on_cc2 <= vconn_side_q;
			vconn_current_clamp <= vconn_cable_switch && oc; // RULE_06
		end
	end

	// sink gate drivers
	logic boot;
	assign boot = ctrl_q[`CTRL_BOOT_MODE];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sink_system_gate_driver <= 1'b0;
			sink_vbus_gate_driver   <= 1'b0;
		end else if (state_q != pp_protect_pkg::st_sink) begin
			sink_system_gate_driver <= 1'b0;
			sink_vbus_gate_driver   <= 1'b0;
		end else if (boot) begin
			sink_system_gate_driver <= !uovp && !safe_strap_configuration; // RULE_11
			sink_vbus_gate_driver   <= !uovp && !safe_strap_configuration; // RULE_11
		end else begin
			sink_system_gate_driver <= !(ctrl_q[`CTRL_OVP_EN] && sovp); // RULE_09
			if (uovp || srcp || vuv)
				sink_vbus_gate_driver <= 1'b0; // RULE_10 RULE_12 RULE_13
			else if (uclr || !sink_vbus_gate_driver)
				sink_vbus_gate_driver <= 1'b1; // RULE_10
		end
	end

	// cc terminations, advertisement, discharge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vbus_discharge            <= 1'b1;
			sink_pulldown_termination <= 1'b0;
			source_advertise          <= pp_protect_pkg::adv_default;
			detach_watch_cc1          <= 1'b1;
			detach_watch_cc2          <= 1'b1;
		end else begin
			vbus_discharge <= state_q == pp_protect_pkg::st_unattached; // RULE_14
			sink_pulldown_termination <= ctrl_q[`CTRL_SNK_MODE]; // RULE_22
			if (!vbus_source_switch)
				source_advertise <= pp_protect_pkg::adv_default; // RULE_20
			else if (ctrl_q[`CTRL_ADV_HI])
				source_advertise <= pp_protect_pkg::adv_3a0;
			else if (ctrl_q[`CTRL_ADV_LO])
				source_advertise <= pp_protect_pkg::adv_1a5;
			detach_watch_cc1 <= !attached || (cc1_t != pp_protect_pkg::cc_open && // RULE_16 RULE_17 RULE_18
				!(ra_rd && cc1_t == pp_protect_pkg::cc_ra));
			detach_watch_cc2 <= !attached || (cc2_t != pp_protect_pkg::cc_open &&
				!(ra_rd && cc2_t == pp_protect_pkg::cc_ra));
		end
	end
	logic unused_in;
	assign unused_in = ^{s_axi_wdata[31:8], s_axi_wstrb[3:1]};
endmodule

// File: pp_protect_props.sv
// port assertions for the power path protection block
// assumes binding onto typec_power_path_protect
module pp_protect_props #(
	parameter int unsigned DEBOUNCE_CYCLES = 16
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        vbus_source_switch,
	input wire logic        vconn_cable_switch,
	input wire logic        vbus_discharge,
	input wire logic        sink_pulldown_termination,
	input wire logic [1:0]  source_advertise,
	input wire logic [3:0]  port_state
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_error_src_off: assert property (port_state == 4'h4 && $past(port_state) == 4'h4 |-> !vbus_source_switch)
		else $error("source switch on in error recovery");
	a_error_cable_off: assert property (port_state == 4'h4 && $past(port_state) == 4'h4 |-> !vconn_cable_switch)
		else $error("cable switch on in error recovery");
	a_unatt_no_power: assert property (port_state == 4'h1 && $past(port_state) == 4'h1
		|-> !vbus_source_switch && !vconn_cable_switch)
		else $error("power applied while unattached");
	a_unatt_discharge: assert property (port_state == 4'h1 && $past(port_state) == 4'h1 |-> vbus_discharge)
		else $error("no discharge while unattached");
	a_default_adv: assert property (!$past(vbus_source_switch) |-> source_advertise == 2'h0)
		else $error("advertisement raised before switch closed");
	a_sink_pulldown: assert property (port_state == 4'h8 && $past(port_state) == 4'h8
		|-> sink_pulldown_termination)
		else $error("sink without pulldown");
	a_state_onehot: assert property ($onehot(port_state))
		else $error("port state not one-hot");
	a_error_holds: assert property ($rose(port_state == 4'h4) |-> ##1 (port_state == 4'h4) [*2])
		else $error("error recovery left at once");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
endmodule

bind typec_power_path_protect pp_protect_props #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.vbus_source_switch(vbus_source_switch), .vconn_cable_switch(vconn_cable_switch),
	.vbus_discharge(vbus_discharge), .sink_pulldown_termination(sink_pulldown_termination),
	.source_advertise(source_advertise), .port_state(port_state)
);

// File: cc_far_end.sv
// far-end termination model: cable, sink or nothing on the cc pins
// assumes attach code {cc1_rd, cc1_ra, cc2_rd, cc2_ra} from the bench
module cc_far_end (
	input  wire logic [3:0] attach,
	output logic            cc1_rd,
	output logic            cc1_ra,
	output logic            cc2_rd,
	output logic            cc2_ra,
	output logic            cc_disconnect
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		{cc1_rd, cc1_ra, cc2_rd, cc2_ra} = attach;
		// nothing terminated: pin floats above the disconnect level
		cc_disconnect = (attach == 4'h0);
	end
endmodule

// File: tb_typec_power_path_protect.sv
// self-checking bench for typec_power_path_protect
// assumes the checker and far-end model compile alongside
`include "pp_protect_regs.svh"
module tb_typec_power_path_protect;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, att, port_state;
	logic [1:0]  s_axi_bresp, s_axi_rresp, source_advertise, adv_lvl;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        vbus_source_switch, vbus_source_fast_on, vconn_cable_switch, vconn_on_cc2, vconn_current_clamp;
	logic        sink_system_gate_driver, sink_vbus_gate_driver, vbus_discharge, sink_pulldown_termination;
	logic        detach_watch_cc1, detach_watch_cc2, c1d, c1a, c2d, c2a, cdis, strap;
	logic [9:0]  fl;
	int          miscompares, comparisons, cycles, i, k;
	// rows: {cc code, expected src/vconn/on_cc2/watch1/watch2, care mask}
	logic [13:0] tv [9] = '{14'h007F, 14'h225B, 14'h0A3B, 14'h105A, 14'h0439, 14'h1B3F, 14'h27DF, 14'h2863, 14'h1463};

	cc_far_end far (.attach(att), .cc1_rd(c1d), .cc1_ra(c1a), .cc2_rd(c2d), .cc2_ra(c2a), .cc_disconnect(cdis));
	typec_power_path_protect #(.DEBOUNCE_CYCLES(16)) dut (
		.*,
		.overtemp_raw(fl[0]), .src_ovp_raw(fl[1]), .rail_uvlo_raw(fl[2]), .src_rcp_raw(fl[3]),
		.vconn_overcurrent_raw(fl[4]), .sys_ovp_raw(fl[5]), .upper_ovp_raw(fl[6]), .upper_ovp_clear_raw(!fl[6]),
		.sink_rcp_raw(fl[7]), .vbus_uvlo_raw(fl[8]), .vbus_present_raw(fl[9]),
		.cc1_rd_raw(c1d), .cc1_ra_raw(c1a), .cc2_rd_raw(c2d), .cc2_ra_raw(c2a), .cc_disconnect_raw(cdis),
		.sink_adv_level(adv_lvl), .safe_strap_configuration(strap)
	);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
		wait_cyc(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b0;
		chk(s_axi_rresp, er);
		chk(s_axi_rdata, e);
		wait_cyc(1);
	endtask

	task automatic detach();
		att <= 4'h0;
		wait_cyc(60);
		chk({port_state, vbus_discharge, vbus_source_switch}, {4'h1, 2'h2});
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		att = 4'h0;
		fl = '0;
		adv_lvl = 2'h0;
		strap = 1'b0;
		miscompares = 0;
		comparisons = 0;
		cycles = 0;
		wait_cyc(12);
		chk({port_state, vbus_discharge, detach_watch_cc1, detach_watch_cc2, vbus_source_switch}, 8'h1E);
		aresetn <= 1'b1;
		wr(`CTRL_OFFSET, 32'h21, 2'h0);
		rd(`CTRL_OFFSET, 32'h21, 2'h0);
		rd(`STATUS_OFFSET, 32'h10, 2'h0);
		rd(8'h0C, 32'h0, 2'h2);
		wr(8'h0C, 32'h0, 2'h2);
		for (i = 0; i < 9; i++) begin
			att <= tv[i][13:10];
			wait_cyc(20);
			chk({vbus_source_switch, vconn_cable_switch, vconn_on_cc2, detach_watch_cc1, detach_watch_cc2} & tv[i][4:0],
				tv[i][9:5] & tv[i][4:0]);
			if (tv[i][4])
				chk(source_advertise, tv[i][9] ? 2'h2 : 2'h0);
			detach();
		end
		for (i = 0; i < 3; i++) begin
			att <= 4'h6;
			wait_cyc(20);
			if (i == 0) begin
				fl[4] <= 1'b1;
				wait_cyc(12);
				chk(vconn_current_clamp, 1'b1);
				fl[4] <= 1'b0;
				wr(`CTRL_OFFSET, 32'h25, 2'h0);
				chk(vbus_source_fast_on, 1'b1);
				fl[3] <= 1'b1;
				wait_cyc(12);
				chk({vbus_source_switch, vbus_source_fast_on}, 2'h0);
				fl[3] <= 1'b0;
				wait_cyc(12);
				chk({vbus_source_switch, vbus_source_fast_on}, 2'h3);
			end
			fl[i] <= 1'b1;
			wait_cyc(12);
			chk({port_state, vbus_source_switch, vconn_cable_switch}, 6'h10);
			fl[i] <= 1'b0;
			wait_cyc(12);
			rd(`FAULT_OFFSET, (i == 0) ? 32'h5 : (i == 1) ? 32'h2 : 32'h8, 2'h0);
			wr(`FAULT_OFFSET, 32'hFF, 2'h0);
			rd(`FAULT_OFFSET, 32'h0, 2'h0);
			wr(`CTRL_OFFSET, 32'hA1, 2'h0);
			wr(`CTRL_OFFSET, 32'h21, 2'h0);
			detach();
		end
		wr(`CTRL_OFFSET, 32'h0A, 2'h0);
		fl[9] <= 1'b1;
		adv_lvl <= 2'h2;
		wait_cyc(20);
		chk({port_state, sink_pulldown_termination, sink_system_gate_driver, sink_vbus_gate_driver}, 7'h47);
		rd(`STATUS_OFFSET, 32'h283, 2'h0);
		for (i = 6; i < 10; i++) begin
			k = (i == 9) ? 5 : i;
			fl[k] <= 1'b1;
			wait_cyc(12);
			chk({sink_system_gate_driver, sink_vbus_gate_driver}, (k == 5) ? 2'h1 : 2'h2);
			fl[k] <= 1'b0;
			wait_cyc(12);
			if (k != 5)
				chk({sink_system_gate_driver, sink_vbus_gate_driver}, 2'h3);
		end
		wr(`CTRL_OFFSET, 32'h02, 2'h0);
		fl[5] <= 1'b1;
		wait_cyc(12);
		chk({sink_system_gate_driver, sink_vbus_gate_driver}, 2'h3);
		fl[5] <= 1'b0;
		wr(`CTRL_OFFSET, 32'h42, 2'h0);
		fl[6] <= 1'b1;
		wait_cyc(12);
		chk({sink_system_gate_driver, sink_vbus_gate_driver}, 2'h0);
		fl[6] <= 1'b0;
		wait_cyc(12);
		chk({sink_system_gate_driver, sink_vbus_gate_driver}, 2'h3);
		strap <= 1'b1;
		wait_cyc(3);
		chk({sink_system_gate_driver, sink_vbus_gate_driver}, 2'h0);
		end_of_test();
	end
endmodule
